//--- shared/gcc_defs.svh
`ifndef GCC_DEFS_SVH
`define GCC_DEFS_SVH
// ==========================================
// Register indices, byte address = 4 * index
`define G_SGAIN  6'h00
`define G_CCG    6'h01
`define G_FILT   6'h02
`define G_DCAP   6'h03
`define G_DVOLT  6'h04
`define G_LMD    6'h05
`define G_ALMT   6'h06
`define G_ALMC   6'h07
`define G_W0     6'h08
`define G_W1     6'h09
`define G_W2     6'h0A
`define G_BLOW   6'h0B
`define G_NEARF  6'h0C
`define G_EMF    6'h0D
`define G_C0     6'h0E
`define G_C1     6'h0F
`define G_R0     6'h10
`define G_R1     6'h11
`define G_TC     6'h12
`define G_OVLD   6'h13
`define G_SDR    6'h14
`define G_EFF    6'h15
`define G_ELOAD  6'h16
`define G_CHGV   6'h17
`define G_OVM    6'h18
`define G_FASTI  6'h19
`define G_MAINI  6'h1A
`define G_PREI   6'h1B
`define G_PREV   6'h1C
`define G_PRET   6'h1D
`define G_OCM    6'h1E
`define G_MAXT   6'h1F
`define G_HYST   6'h20
`define G_MAXOVC 6'h21
`define G_FCCLR  6'h22
`define G_CTRL   6'h23
`define G_NCFG   6'h24
`define G_STAT   6'h24
`define G_RM     6'h25
`define G_FCC    6'h26
`define G_CHGI   6'h27
`define G_DCAPR  6'h28
// ==========================================
// Reset values and fixed figures
`define G_CCG_RST  32'h0100_0000
`define G_EFF_RST  32'h0000_00FF
`define G_CTRL_RST 32'h0000_000C
`define G_T_COLD   16'h00E6
`define G_T_CLR    16'h01AE
`define G_PCT_MIN  7'h03
`define G_PCT_MAX  7'h13
`define G_PCT_LOW1 8'h03
`define G_HUNDRED  7'h64
`define G_PPD      40'h00_0000_2710
`define G_MWH_DIV  32'h0000_2710
`define G_EL_DAY   16'h0624
`define G_R_DIV    48'h0000_0003_E800
`endif

//--- shared/gcc_pkg.sv
// ==========================================
// Shared types
package gcc_pkg;
    typedef logic [15:0] gcc_word_t;
    typedef enum logic [1:0] {lrn_idle, lrn_track} gcc_lrn_e;
endpackage

//--- hdl/gcc_gauge.sv
`timescale 1ns/1ps
`include "gcc_defs.svh"
// Overview of operation
// RULE_01: Converter result times 16-bit gain gives charge in mAh.
// RULE_02: Results below stored filter threshold (290 nV steps) are ignored.
// RULE_03: Design capacity reported as stored, or times voltage in 10 mWh.
// RULE_04: Learning refreshes last discharge; full capacity derives from it.
// RULE_05: Time and capacity alarm thresholds come from stored constants.
// RULE_06: Compensation off uses stored warning levels, on computes them.
// RULE_07: Battery-low percentage, clamped 3 to 19, corrects learned capacity.
// RULE_08: Learning qualifies only if started inside near-full window.
// RULE_09: Level equals cells times (voltage times factor minus load drop).
// RULE_10: Cold impedance factor applies only below 23 degrees.
// RULE_11: Discharge disabled when discharge current breaches overload limit.
// RULE_12: Self-discharge applied daily at 0.01 percent per count; code skips a day_tick that coincides with cc_take.
// RULE_13: Charge added scaled by efficiency code plus one over 256.
// RULE_14: Electronics load in microamps is three times stored value.
// RULE_15: Charging voltage reported; above it plus margin suspends charge.
// RULE_16: Fast charge permitted requests the fast-charge current.
// RULE_17: Termination requests zero, then maintenance once it ends.
// RULE_18: Low voltage or cool temperature requests precharge current.
// RULE_19: Charge current at or above request plus margin forces zero.
// RULE_20: Over-temperature set at limit, cleared by hysteresis or 43.0 C.
// RULE_21: Charging past full by maximum overcharge suspends charge.
// RULE_22: Fully-charged flag cleared when state of charge reaches threshold.
// RULE_23: 32-bit gain corrects accumulated charge for resistor variation.
// RULE_24: Any suspension forces zero over every other selection.
module gcc_gauge (
    input  wire logic              aclk,          // 200 MHz clock
    input  wire logic              aresetn,       // Sync reset, low
    input  wire logic [7:0]        s_awaddr,      // Write address
    input  wire logic              s_awvalid,     // Write address valid
    output logic                   s_awready,     // Write address ready
    input  wire logic [31:0]       s_wdata,       // Write data
    input  wire logic [3:0]        s_wstrb,       // Byte strobes
    input  wire logic              s_wvalid,      // Write data valid
    output logic                   s_wready,      // Write data ready
    output logic [1:0]             s_bresp,       // Write response
    output logic                   s_bvalid,      // Response valid
    input  wire logic              s_bready,      // Response ready
    input  wire logic [7:0]        s_araddr,      // Read address
    input  wire logic              s_arvalid,     // Read address valid
    output logic                   s_arready,     // Read address ready
    output logic [31:0]            s_rdata,       // Read data
    output logic [1:0]             s_rresp,       // Read response
    output logic                   s_rvalid,      // Read valid
    input  wire logic              s_rready,      // Read ready
    input  wire gcc_pkg::gcc_word_t cc_result,    // Converter result
    input  wire logic              cc_strobe,     // Result pulse
    input  wire gcc_pkg::gcc_word_t pack_mv,      // Pack voltage mV
    input  wire gcc_pkg::gcc_word_t temp_dc,      // Temp, 0.1 C signed
    input  wire gcc_pkg::gcc_word_t current_ma,   // Current, signed
    input  wire logic              day_tick,      // One pulse per day
    input  wire logic              fast_term,     // Termination level
    output gcc_pkg::gcc_word_t     charging_current,  // Request mA
    output gcc_pkg::gcc_word_t     charging_voltage,  // Request mV
    output gcc_pkg::gcc_word_t     design_capacity,   // mAh or 10 mWh
    output gcc_pkg::gcc_word_t     full_capacity_value,
    output gcc_pkg::gcc_word_t     remaining_capacity_value,
    output gcc_pkg::gcc_word_t     alarm_time_min,    // Cmd 0x01 value
    output gcc_pkg::gcc_word_t     alarm_capacity,    // Cmd 0x02 value
    output gcc_pkg::gcc_word_t     warn_level_low,    // Lowest level
    output gcc_pkg::gcc_word_t     warn_level_mid,    // Middle level
    output gcc_pkg::gcc_word_t     warn_level_high,   // Highest level
    output gcc_pkg::gcc_word_t     electronics_load_estimate, // uA
    output logic                   discharge_disable, // Overload
    output logic                   fully_charged      // Status flag
);
    import gcc_pkg::*;
    localparam int NCFG = int'(`G_NCFG);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================
    // Register bus
    logic [31:0] cfg [0:NCFG-1];
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [7:0]  stat;
    logic [15:0] rsoc_w;
    // One write and one read in flight; address and data in either order
    assign s_awready = !aw_ok;
    assign s_wready  = !w_ok;
    assign s_arready = !s_rvalid;
    wire         do_wr  = aw_ok && w_ok && !s_bvalid;
    wire [5:0]   wi     = wa[7:2];
    wire         wr_hit = wi < `G_NCFG;
    wire [31:0]  wmask  = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire [5:0]   ri     = s_araddr[7:2];
    wire         rd_cfg = ri < `G_NCFG;
    wire         rd_hit = ri <= `G_DCAPR;
    wire [31:0]  rd_val = rd_cfg ? cfg[ri] :
                          ri == `G_STAT ? {24'h0, stat} :
                          ri == `G_RM ? {16'h0, remaining_capacity_value} :
                          ri == `G_FCC ? {16'h0, full_capacity_value} :
                          ri == `G_CHGI ? {16'h0, charging_current} :
                          ri == `G_DCAPR ? {16'h0, design_capacity} : 32'h0;

    // Channel holding and responses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            wa <= 8'h00;
            wd <= 32'h0000_0000;
            ws <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
            s_rvalid <= 1'b0;
            s_rresp <= 2'h0;
            s_rdata <= 32'h0000_0000;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_ok <= 1'b1;
                wa <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_ok <= 1'b1;
                wd <= s_wdata;
                ws <= s_wstrb;
            end
            if (do_wr) begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_val;
                s_rresp <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Stored constants
    wire [15:0] sgain  = cfg[`G_SGAIN][15:0];
    wire [31:0] ccg    = cfg[`G_CCG];
    wire [15:0] lmd    = cfg[`G_LMD][15:0];
    wire [7:0]  eff    = cfg[`G_EFF][7:0];
    wire [7:0]  sdr    = cfg[`G_SDR][7:0];
    wire [15:0] c0     = cfg[`G_C0][15:0];
    wire [7:0]  c1     = cfg[`G_C1][7:0];
    wire [15:0] r0     = cfg[`G_R0][15:0];
    wire [15:0] r1     = cfg[`G_R1][15:0];
    wire [7:0]  tc     = cfg[`G_TC][7:0];
    wire        mwh    = cfg[`G_CTRL][0];
    wire        comp   = cfg[`G_CTRL][1];
    wire [2:0]  cells  = cfg[`G_CTRL][4:2];
    wire signed [15:0] t   = $signed(temp_dc);
    wire signed [15:0] cur = $signed(current_ma);
    wire        chg    = cur > 16'sh0000;
    wire [15:0] load_current_magnitude  = cur < 16'sh0000 ? 16'(-cur) : 16'h0000;
    // Clamp keeps the learning divisor well away from zero
    wire [6:0]  blow   = cfg[`G_BLOW][6:0];
    wire [6:0]  pct    = blow < `G_PCT_MIN ? `G_PCT_MIN :
                         blow > `G_PCT_MAX ? `G_PCT_MAX : blow; // RULE_07
    gcc_lrn_e    lrn;
    logic [31:0] dis_q;
    wire  [22:0] lrn_p   = 23'(dis_q[31:16]) * 23'(`G_HUNDRED);
    wire  [15:0] lmd_new = 16'(lrn_p / 23'(`G_HUNDRED - pct)); // RULE_07
    wire         lrn_done = lrn == lrn_track && pack_mv < warn_level_high; // RULE_08

    // Bus writes with byte lanes; a learned value overrides a same-cycle write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NCFG; i++) begin
                cfg[i] <= 32'h0000_0000;
            end
            cfg[`G_CCG] <= `G_CCG_RST;
            cfg[`G_EFF] <= `G_EFF_RST;
            cfg[`G_CTRL] <= `G_CTRL_RST;
        end else begin
            if (do_wr && wr_hit) begin
                cfg[wi] <= (cfg[wi] & ~wmask) | (wd & wmask);
            end
            if (lrn_done) begin
                cfg[`G_LMD] <= {16'h0000, lmd_new}; // RULE_04
            end
        end
    end

    // ==========================================
    // Coulomb counting
    logic [31:0] rm_q;
    logic [31:0] ovc_q;
    logic [31:0] next_rm;
    logic [31:0] next_ovc;
    wire [15:0] cc_abs  = cur_abs(cc_result);
    wire        cc_take = cc_strobe && cc_abs >= cfg[`G_FILT][15:0]; // RULE_02
    wire signed [32:0] raw   = $signed(cc_result) * $signed({1'b0, sgain}); // RULE_01
    wire signed [65:0] cor_p = 66'(raw) * $signed({34'h0, ccg}); // RULE_23
    wire signed [31:0] delta = cor_p[63:32];
    wire signed [41:0] eff_p = 42'(delta) * $signed({33'h0, 9'(eff) + 9'h001});
    wire signed [31:0] d_q   = delta[31] ? delta : eff_p[39:8]; // RULE_13
    wire signed [33:0] rm_sum = $signed({2'b00, rm_q}) + 34'(d_q);
    wire [31:0] full_q  = {lmd, 16'h0000};
    wire [39:0] sd_p    = 40'(rm_q) * 40'(sdr);
    wire [31:0] sd_q    = 32'(sd_p / `G_PPD) + 32'(electronics_load_estimate * `G_EL_DAY); // RULE_12
    wire [22:0] soc_p   = 23'(rm_q[31:16]) * 23'(`G_HUNDRED);
    assign rsoc_w = lmd == 16'h0000 ? 16'h0000 : 16'(soc_p / 23'(lmd));

    function automatic logic [15:0] cur_abs(input logic [15:0] v);
        return v[15] ? 16'(-$signed(v)) : v;
    endfunction

    // Capacity add, clamp at full and overcharge tally
    always_comb begin
        next_rm = rm_q;
        next_ovc = ovc_q;
        if (cc_take) begin
            if (rm_sum < 34'sh0) begin
                next_rm = 32'h0000_0000;
            end else if (rm_sum > $signed({2'b00, full_q})) begin
                next_rm = full_q;
                next_ovc = ovc_q + 32'(rm_sum - $signed({2'b00, full_q})); // RULE_21
            end else begin
                next_rm = rm_sum[31:0];
            end
        end else if (day_tick) begin
            next_rm = rm_q > sd_q ? rm_q - sd_q : 32'h0000_0000;
        end
        if (!fully_charged) begin
            next_ovc = 32'h0000_0000;
        end
    end

    // Learning tracks discharge from near full down to the highest level
    wire near = 17'(remaining_capacity_value) + 17'(cfg[`G_NEARF][15:0]) >= 17'(lmd); // RULE_08
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rm_q <= 32'h0000_0000;
            ovc_q <= 32'h0000_0000;
            lrn <= lrn_idle;
            dis_q <= 32'h0000_0000;
        end else begin
            rm_q <= next_rm;
            ovc_q <= next_ovc;
            case (lrn)
                lrn_idle: begin
                    dis_q <= 32'h0000_0000;
                    if (cur < 16'sh0000 && near) begin
                        lrn <= lrn_track;
                    end
                end
                default: begin
                    if (cc_take && d_q < 0) begin
                        dis_q <= dis_q + 32'(-d_q);
                    end
                    if (chg || lrn_done) begin
                        lrn <= lrn_idle;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Warning levels
    function automatic logic [15:0] wcalc(input logic [7:0] c);
        logic [8:0]  k;
        logic [15:0] capacity_temp_factor;
        logic [31:0] cold;
        logic [47:0] resistance_temp_factor;
        logic [47:0] v;
        logic [47:0] l;
        k = 9'(c) + 9'(c1);
        if (k > 9'(`G_HUNDRED)) begin
            k = 9'(`G_HUNDRED);
        end
        cold = 32'h0;
        if (t < $signed(`G_T_COLD)) begin
            cold = (32'(tc) * 32'($signed(`G_T_COLD) - t)) >> 4; // RULE_10
        end
        capacity_temp_factor = 16'h0100 + 16'(k) - 16'(c0 >> 4);
        resistance_temp_factor = 48'h100 + ((48'(r1) * 48'(9'(`G_HUNDRED) - k)) >> 8) + 48'(cold);
        v = (48'(cfg[`G_EMF][15:0]) * 48'(capacity_temp_factor)) >> 8;
        l = 48'(load_current_magnitude) * 48'(r0) * resistance_temp_factor / `G_R_DIV;
        return 16'((v > l ? v - l : 48'h0) * 48'(cells)); // RULE_09
    endfunction

    // ==========================================
    // Charge control
    logic oc;
    logic ot;
    logic term_seen;
    wire [16:0] ov_lim = 17'(cfg[`G_CHGV][15:0]) + 17'(cfg[`G_OVM][15:0]);
    wire ov  = 17'(pack_mv) > ov_lim; // RULE_15
    wire [16:0] oc_lim = 17'(charging_current) + 17'(cfg[`G_OCM][15:0]);
    wire oc_hit = chg && 17'(cur) >= oc_lim; // RULE_19
    wire ot_set = t >= $signed(cfg[`G_MAXT][15:0]); // RULE_20
    wire ot_clr = t <= $signed(cfg[`G_MAXT][15:0]) - $signed(16'(cfg[`G_HYST][7:0])) * 16'sh000A ||
                  t <= $signed(`G_T_CLR); // RULE_20
    wire ovc = fully_charged && ovc_q[31:16] >= cfg[`G_MAXOVC][15:0]; // RULE_21
    wire susp = oc || ov || ot || ovc; // RULE_24
    wire pre = pack_mv < warn_level_low || pack_mv < cfg[`G_PREV][15:0] ||
               (t > 16'sh0000 && t < $signed(cfg[`G_PRET][15:0])); // RULE_18
    wire fc_clr = rsoc_w <= {8'h00, cfg[`G_FCCLR][7:0]}; // RULE_22
    // Suspension outranks precharge, termination and fast
    wire [15:0] next_chg_i = susp ? 16'h0000 : // RULE_24
                             pre ? cfg[`G_PREI][15:0] : // RULE_18
                             fast_term ? 16'h0000 : // RULE_17
                             term_seen ? cfg[`G_MAINI][15:0] : // RULE_17
                             cfg[`G_FASTI][15:0]; // RULE_16
    assign stat = {fully_charged, term_seen, oc, ov, ot, ovc, discharge_disable, lrn == lrn_track};

    // Flags and registered outputs; set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oc <= 1'b0;
            ot <= 1'b0;
            term_seen <= 1'b0;
            fully_charged <= 1'b0;
            charging_current <= 16'h0000;
            discharge_disable <= 1'b0;
            warn_level_low <= 16'h0000;
            warn_level_mid <= 16'h0000;
            warn_level_high <= 16'h0000;
            design_capacity <= 16'h0000;
            full_capacity_value <= 16'h0000;
        end else begin
            oc <= oc_hit || (oc && chg); // RULE_19
            ot <= ot_set || (ot && !ot_clr); // RULE_20
            term_seen <= fast_term || (term_seen && !fc_clr);
            fully_charged <= fast_term || (fully_charged && !fc_clr); // RULE_22
            charging_current <= next_chg_i;
            discharge_disable <= load_current_magnitude > cfg[`G_OVLD][15:0]; // RULE_11
            warn_level_low <= comp ? wcalc(8'h00) : cfg[`G_W0][15:0]; // RULE_06
            warn_level_mid <= comp ? wcalc(`G_PCT_LOW1) : cfg[`G_W1][15:0]; // RULE_06
            warn_level_high <= comp ? wcalc({1'b0, pct}) : cfg[`G_W2][15:0]; // RULE_06
            design_capacity <= mwh ? 16'(32'(cfg[`G_DCAP][15:0]) * 32'(cfg[`G_DVOLT][15:0]) /
                                     `G_MWH_DIV) : cfg[`G_DCAP][15:0]; // RULE_03
            full_capacity_value <= mwh ? 16'(32'(lmd) * 32'(cfg[`G_DVOLT][15:0]) /
                                         `G_MWH_DIV) : lmd; // RULE_04
        end
    end
    assign remaining_capacity_value = rm_q[31:16];
    assign charging_voltage = cfg[`G_CHGV][15:0]; // RULE_15
    assign alarm_time_min = cfg[`G_ALMT][15:0]; // RULE_05
    assign alarm_capacity = cfg[`G_ALMC][15:0]; // RULE_05
    assign electronics_load_estimate = 16'(cfg[`G_ELOAD][7:0]) * 16'h0003; // RULE_14

    // ==========================================
    // Checks
    susp_zero_a: assert property (susp |=> charging_current == 16'h0000) // RULE_24
        else $error("suspension did not zero request");
    fast_sel_a: assert property (!susp && !pre && !fast_term && !term_seen
        |=> charging_current == $past(cfg[`G_FASTI][15:0])) // RULE_16
        else $error("fast current not requested");
    maint_sel_a: assert property (!susp && !pre && !fast_term && term_seen
        |=> charging_current == $past(cfg[`G_MAINI][15:0])) // RULE_17
        else $error("maintenance current not requested");
    term_zero_a: assert property (!susp && !pre && fast_term |=> charging_current == 16'h0000) // RULE_17
        else $error("termination did not zero request");
    pre_sel_a: assert property (!susp && pre |=> charging_current == $past(cfg[`G_PREI][15:0])) // RULE_18
        else $error("precharge current not requested");
    overload_a: assert property (load_current_magnitude > cfg[`G_OVLD][15:0] |=> discharge_disable) // RULE_11
        else $error("overload did not disable discharge");
    ot_clear_a: assert property (ot && !ot_set && t <= $signed(`G_T_CLR) |=> !ot) // RULE_20
        else $error("over-temperature not cleared");
    full_clear_a: assert property (fully_charged && fc_clr && !fast_term |=> !fully_charged) // RULE_22
        else $error("fully charged flag not cleared");
    fixed_warn_a: assert property (!comp |=> warn_level_high == $past(cfg[`G_W2][15:0])) // RULE_06
        else $error("fixed warning level not used");
    write_resp_a: assert property (do_wr |=> s_bvalid && !aw_ok && !w_ok)
        else $error("write response missing");
    fast_to_maint_c: cover property (fast_term ##1 !fast_term ##1 charging_current == cfg[`G_MAINI][15:0]);
    learn_done_c: cover property (lrn_done);
    ot_hit_c: cover property (ot ##[1:20] !ot);
    pre_hit_c: cover property (pre && !susp);
endmodule // gcc_gauge

//--- test/gcc_charger.sv
`timescale 1ns/1ps
// ==========================================
// Charger model on the far side of the request
module gcc_charger (
    input  wire logic        aclk,   // Clock
    input  wire logic [15:0] req_ma, // Requested current
    input  wire logic        on,     // Charger connected
    input  wire logic [15:0] extra,  // Commanded overshoot
    output logic [15:0]      chg_ma  // Current into pack
);
    // One cycle of lag, since no real charger follows at once
    always_ff @(posedge aclk) begin
        chg_ma <= on ? req_ma + extra : 16'h0000;
    end
endmodule // gcc_charger

//--- test/test_gcc_gauge.sv
`timescale 1ns/1ps
`include "gcc_defs.svh"
// ==========================================
// Bench for the gauge and charge control block
module test_gcc_gauge;
    import gcc_pkg::*;
    logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, cc_strobe, day_tick, fast_term;
    logic        discharge_disable, fully_charged, chg_on;
    logic [7:0]  s_awaddr, s_araddr;
    logic [3:0]  s_wstrb;
    logic [31:0] s_wdata, s_rdata;
    logic [1:0]  s_bresp, s_rresp;
    gcc_word_t   cc_result, pack_mv, temp_dc, current_ma, dsg_ma, chg_ma, extra;
    gcc_word_t   charging_current, charging_voltage, design_capacity, full_capacity_value;
    gcc_word_t   remaining_capacity_value, alarm_time_min, alarm_capacity, warn_level_low;
    gcc_word_t   warn_level_mid, warn_level_high, electronics_load_estimate;
    int          bad_count, cmp_count;

    gcc_gauge gcc_gauge_inst (.*);
    gcc_charger gcc_charger_inst (.aclk(aclk), .req_ma(charging_current), .on(chg_on),
        .extra(extra), .chg_ma(chg_ma));
    // Charger current while connected, else the bench load
    assign current_ma = chg_on ? chg_ma : dsg_ma;

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ==========================================
    // Reporting
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        chk32({16'h0000, got}, {16'h0000, exp});
    endtask
    task automatic stop_test();
        $display("Counts: bad=%0d compared=%0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // Bus cycles: handshakes sampled at the rising edge, released right after it
    task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic tb;
        logic [1:0] r;
        @(posedge aclk);
        n = 0;
        s_awaddr <= {i, 2'b00};
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            tb = s_bvalid;
            r = s_bresp;
            n++;
        end while (!tb && n < 64);
        s_bready <= 1'b0;
        if (!tb) begin
            bad_count++;
            stop_test();
        end
        chk32({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [5:0] i, input logic [31:0] ed, input logic [1:0] er);
        int   n;
        logic tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        n = 0;
        s_araddr <= {i, 2'b00};
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            tr = s_rvalid;
            d = s_rdata;
            r = s_rresp;
            n++;
        end while (!tr && n < 64);
        s_rready <= 1'b0;
        if (!tr) begin
            bad_count++;
            stop_test();
        end
        chk32(d, ed);
        chk32({30'h0, r}, {30'h0, er});
    endtask
    // Apply pack conditions, then let the outputs settle
    task automatic drv(input logic [15:0] pv, input logic [15:0] t, input logic [15:0] dm);
        @(posedge aclk);
        pack_mv <= pv;
        temp_dc <= t;
        dsg_ma <= dm;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        rd(`G_CCG, `G_CCG_RST, 2'b00);
        rd(`G_EFF, `G_EFF_RST, 2'b00);
        rd(`G_CTRL, `G_CTRL_RST, 2'b00);
        rd(6'h29, 32'h0000_0000, 2'b10);
        wr(`G_STAT, 32'h0000_00FF, 2'b10);
        $display("regs done");
    endtask
    task automatic t_cfg();
        logic [5:0]  ix [20] = '{`G_DCAP, `G_DVOLT, `G_ALMT, `G_ALMC, `G_W0, `G_W1, `G_W2, `G_ELOAD,
            `G_CHGV, `G_OVM, `G_FASTI, `G_MAINI, `G_PREI, `G_PREV, `G_PRET, `G_OCM, `G_MAXT, `G_HYST, `G_OVLD, `G_LMD};
        logic [15:0] vl [20] = '{16'h07D0, 16'h2AF8, 16'h000A, 16'h012C, 16'h2328, 16'h2454, 16'h2580,
            16'h0007, 16'h3138, 16'h00C8, 16'h0BB8, 16'h0096, 16'h01F4, 16'h251C, 16'h0064, 16'h0064,
            16'h01F4, 16'h0005, 16'h1388, 16'h07D0};
        foreach (ix[k]) wr(ix[k], {16'h0000, vl[k]}, 2'b00);
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        chk16(design_capacity, 16'h07D0);
        chk16(full_capacity_value, 16'h07D0);
        chk16(alarm_time_min, 16'h000A);
        chk16(alarm_capacity, 16'h012C);
        chk16(warn_level_low, 16'h2328);
        chk16(warn_level_mid, 16'h2454);
        chk16(warn_level_high, 16'h2580);
        chk16(electronics_load_estimate, 16'h0015);
        chk16(charging_voltage, 16'h3138);
        chk16(charging_current, 16'h0BB8);
        wr(`G_CTRL, 32'h0000_000D, 2'b00);
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        chk16(design_capacity, 16'h0898);
        chk16(full_capacity_value, 16'h0898);
        wr(`G_CTRL, 32'h0000_000C, 2'b00);
        $display("config done");
    endtask
    // Overload, overvoltage and over-temperature set limits tried one step either side of their boundary
    task automatic t_limits();
        drv(16'h2EE0, 16'h00FA, 16'hEC77);
        chk16({15'h0, discharge_disable}, 16'h0001);
        drv(16'h2EE0, 16'h00FA, 16'hEC78);
        chk16({15'h0, discharge_disable}, 16'h0000);
        drv(16'h23F0, 16'h00FA, 16'h0000);
        chk16(charging_current, 16'h01F4);
        drv(16'h2EE0, 16'h0032, 16'h0000);
        chk16(charging_current, 16'h01F4);
        drv(16'h3201, 16'h00FA, 16'h0000);
        chk16(charging_current, 16'h0000);
        drv(16'h3200, 16'h01F3, 16'h0000);
        chk16(charging_current, 16'h0BB8);
        drv(16'h2EE0, 16'h01F4, 16'h0000);
        chk16(charging_current, 16'h0000);
        drv(16'h2EE0, 16'h01CC, 16'h0000);
        chk16(charging_current, 16'h0000);
        drv(16'h2EE0, 16'h01C2, 16'h0000);
        chk16(charging_current, 16'h0BB8);
        $display("limits done");
    endtask
    // Charger overshoot just under, then at, the margin
    task automatic t_charge();
        @(posedge aclk);
        extra <= 16'h0063;
        chg_on <= 1'b1;
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        chk16(charging_current, 16'h0BB8);
        @(posedge aclk);
        extra <= 16'h0064;
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        chk16(charging_current, 16'h0000);
        @(posedge aclk);
        chg_on <= 1'b0;
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        @(posedge aclk);
        fast_term <= 1'b1;
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        chk16(charging_current, 16'h0000);
        chk16({15'h0, fully_charged}, 16'h0001);
        @(posedge aclk);
        fast_term <= 1'b0;
        drv(16'h2EE0, 16'h00FA, 16'h0000);
        chk16({15'h0, fully_charged}, 16'h0000);
        $display("charge done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, cc_strobe, day_tick, fast_term, chg_on} = '0;
        {s_awaddr, s_araddr, s_wdata, cc_result, dsg_ma, extra} = '0;
        s_wstrb = 4'hF;
        pack_mv = 16'h2EE0;
        temp_dc = 16'h00FA;
        bad_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_cfg();
        t_limits();
        t_charge();
        stop_test();
    end
endmodule // test_gcc_gauge
